// >>> design/cbtx_pkg.sv
// Package of register offsets, reset values and widths for the buffer transmit-request block.
`default_nettype none
package cbtx_pkg;
	localparam int          NUM_BUF          = 8;
	localparam logic [7:0]  OFS_ID_FORMAT    = 8'h00;
	localparam logic [7:0]  OFS_TX_REQUEST   = 8'h04;
	localparam logic [7:0]  OFS_ENABLE       = 8'h08;
	localparam logic [7:0]  OFS_CANCEL       = 8'h0C;
	localparam logic [7:0]  OFS_FRAME_TYPE   = 8'h10;
	localparam logic [7:0]  OFS_REMOTE_WAIT  = 8'h14;
	localparam logic [7:0]  OFS_RX_REMOTE    = 8'h18;
	localparam logic [7:0]  OFS_CTRL         = 8'h1C;
	localparam logic [7:0]  RST_ID_FORMAT    = 8'h00;
	localparam logic [7:0]  RST_TX_REQUEST   = 8'h00;
	localparam logic [7:0]  RST_ENABLE       = 8'h00;
	localparam logic [7:0]  RST_FRAME_TYPE   = 8'h00;
	localparam logic [7:0]  RST_REMOTE_WAIT  = 8'h00;
	localparam logic [7:0]  RST_RX_REMOTE    = 8'h00;
	localparam int          CTRL_RMW_BIT     = 0;
	localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;
endpackage : cbtx_pkg
`default_nettype wire

// >>> design/cbtx_pick.sv
// Lowest-numbered eligible buffer picker.
`default_nettype none
module cbtx_pick #(
	parameter int N = 8
) (
	input  wire logic [N-1:0]         eligible_in,
	output logic                      found_out,
	output logic [$clog2(N)-1:0]      index_out
);
	always_comb
	begin
		found_out = 1'b0;
		index_out = '0;
		for (int i = N - 1; i >= 0; i--)
		begin
			if (eligible_in[i])
			begin
				found_out = 1'b1;
				index_out = i[$clog2(N)-1:0];
			end
		end
	end
endmodule : cbtx_pick
`default_nettype wire

// >>> design/cbtx_top.sv
// Per-buffer identifier format and transmit-request control with a Wishbone slave.
`default_nettype none
module cbtx_top #(
	parameter int N = 8
) (
	input  wire logic                 ref_clk_in,
	input  wire logic                 nrst_in,
	input  wire logic                 wb_cyc_in,
	input  wire logic                 wb_stb_in,
	input  wire logic                 wb_we_in,
	input  wire logic [7:0]           wb_adr_in,
	input  wire logic [3:0]           wb_sel_in,
	input  wire logic [31:0]          wb_dat_in,
	output logic [31:0]               wb_dat_out,
	output logic                      wb_ack_out,
	input  wire logic                 tx_busy_in,
	input  wire logic                 tx_done_in,
	input  wire logic [$clog2(N)-1:0] tx_done_idx_in,
	input  wire logic                 rx_remote_in,
	input  wire logic [$clog2(N)-1:0] rx_remote_idx_in,
	output logic                      tx_start_out,
	output logic [$clog2(N)-1:0]      tx_idx_out,
	output logic                      tx_remote_out,
	output logic                      tx_ext_id_out,
	output logic [N-1:0]              buffer_enable_bit_out,
	output logic [N-1:0]              id_length_select_bits_out
);
	// ****************************************
	// Bus decode
	// ****************************************
	localparam int IW = $clog2(N);
	logic          acc;
	logic          wr;
	logic          rmw_q;
	logic [N-1:0]  id_fmt_q;
	logic [N-1:0]  send_pending_q;
	logic [N-1:0]  enable_q;
	logic [N-1:0]  frame_type_q;
	logic [N-1:0]  remote_wait_q;
	logic [N-1:0]  rx_remote_q;
	logic [N-1:0]  wdat;
	logic [N-1:0]  set_req;
	logic [N-1:0]  cancel;
	logic [N-1:0]  done_clr;
	logic [N-1:0]  rx_set;
	logic [N-1:0]  eligible;
	logic          found;
	logic [IW-1:0] pick_idx;
	logic          in_flight;
	logic [IW-1:0] cur_idx_q;
	logic          wr_fmt;
	logic          wr_req;
	logic          wr_en;
	logic          wr_can;
	logic          wr_type;
	logic          wr_wait;
	logic          wr_rxr;
	logic          wr_ctrl;
	logic [N-1:0]  req_clr;
	logic [N-1:0]  rx_clr;
	logic [31:0]   rd_word;

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_SENDING
	} cbtx_launch_t;
	cbtx_launch_t  launch_q;

	// A request is taken when cyc and stb first meet; it is answered one cycle later.
	assign acc  = wb_cyc_in && wb_stb_in && !wb_ack_out;
	// Writes land on the edge at which the master sees ack, so both sides agree
	// on the cycle in which a register changes.
	assign wr   = wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in && wb_sel_in[0];
	assign wdat = wb_dat_in[N-1:0];

	// ****************************************
	// Write strobes
	// ****************************************
	assign wr_fmt  = wr && wb_adr_in == cbtx_pkg::OFS_ID_FORMAT;
	assign wr_req  = wr && wb_adr_in == cbtx_pkg::OFS_TX_REQUEST;
	assign wr_en   = wr && wb_adr_in == cbtx_pkg::OFS_ENABLE;
	assign wr_can  = wr && wb_adr_in == cbtx_pkg::OFS_CANCEL;
	assign wr_type = wr && wb_adr_in == cbtx_pkg::OFS_FRAME_TYPE;
	assign wr_wait = wr && wb_adr_in == cbtx_pkg::OFS_REMOTE_WAIT;
	assign wr_rxr  = wr && wb_adr_in == cbtx_pkg::OFS_RX_REMOTE;
	assign wr_ctrl = wr && wb_adr_in == cbtx_pkg::OFS_CTRL;

	always_ff @(posedge ref_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			wb_ack_out <= 1'b0;
		else
			wb_ack_out <= acc;
	end

	// ****************************************
	// Software-owned registers
	// ****************************************
	// Format changes are not blocked while enabled; keeping them safe is software's job.
	always_ff @(posedge ref_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			id_fmt_q <= N'(cbtx_pkg::RST_ID_FORMAT);
		else if (wr_fmt)
			id_fmt_q <= wdat;
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			enable_q <= N'(cbtx_pkg::RST_ENABLE);
		else if (wr_en)
			enable_q <= wdat;
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			frame_type_q <= N'(cbtx_pkg::RST_FRAME_TYPE);
		else if (wr_type)
			frame_type_q <= wdat;
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			remote_wait_q <= N'(cbtx_pkg::RST_REMOTE_WAIT);
		else if (wr_wait)
			remote_wait_q <= wdat;
	end

	always_ff @(posedge ref_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			rmw_q <= 1'b0;
		else if (wr_ctrl)
			rmw_q <= wb_dat_in[cbtx_pkg::CTRL_RMW_BIT];
	end

	// ****************************************
	// Per-buffer request, cancel and remote flags
	// ****************************************
	assign set_req = wr_req ? wdat : '0;
	assign cancel  = wr_can ? wdat : '0;

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_buf
			assign done_clr[g] = tx_done_in && tx_done_idx_in == IW'(g);
			assign rx_set[g]   = rx_remote_in && rx_remote_idx_in == IW'(g)
				&& enable_q[g];
			// Completion and cancel both beat a software set landing in the same cycle.
			assign req_clr[g]  = done_clr[g] || cancel[g];
			// Software can only clear the received-remote flag; a new arrival still wins.
			assign rx_clr[g]   = done_clr[g] || (wr_rxr && !wdat[g]);
			// A wait-enabled data request sends only after a remote frame arrives.
			assign eligible[g] = send_pending_q[g] && enable_q[g]
				&& (!remote_wait_q[g] || frame_type_q[g] || rx_remote_q[g]);

			always_ff @(posedge ref_clk_in or negedge nrst_in)
			begin
				if (!nrst_in)
					send_pending_q[g] <= cbtx_pkg::RST_TX_REQUEST[g];
				else if (req_clr[g])
					send_pending_q[g] <= 1'b0;
				else if (set_req[g])
					send_pending_q[g] <= 1'b1;
			end

			// A received remote frame is consumed when the answering send completes.
			always_ff @(posedge ref_clk_in or negedge nrst_in)
			begin
				if (!nrst_in)
					rx_remote_q[g] <= cbtx_pkg::RST_RX_REMOTE[g];
				else if (rx_set[g])
					rx_remote_q[g] <= 1'b1;
				else if (rx_clr[g])
					rx_remote_q[g] <= 1'b0;
			end
		end
	endgenerate

	// ****************************************
	// Arbitration and launch
	// ****************************************
	cbtx_pick #(
		.N(N)
	) u_pick (
		.eligible_in (eligible),
		.found_out   (found),
		.index_out   (pick_idx)
	);

	always_ff @(posedge ref_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			launch_q  <= ST_IDLE;
			cur_idx_q <= '0;
		end
		else
		begin
			unique case (launch_q)
				ST_IDLE:
				begin
					if (!tx_busy_in && found)
					begin
						launch_q  <= ST_SENDING;
						cur_idx_q <= pick_idx;
					end
				end
				ST_SENDING:
				begin
					// Cancelling the request in flight frees the launcher one cycle after its pending bit clears.
					if (tx_done_in || !send_pending_q[cur_idx_q])
						launch_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign in_flight = launch_q == ST_SENDING;

	// ****************************************
	// Launch outputs
	// ****************************************

	always_ff @(posedge ref_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			tx_start_out  <= 1'b0;
			tx_idx_out    <= '0;
			tx_remote_out <= 1'b0;
			tx_ext_id_out <= 1'b0;
		end
		else
		begin
			tx_start_out <= !in_flight && !tx_busy_in && found;
			if (!in_flight && found)
			begin
				tx_idx_out    <= pick_idx;
				tx_remote_out <= frame_type_q[pick_idx];
				tx_ext_id_out <= id_fmt_q[pick_idx];
			end
		end
	end

	// ****************************************
	// Level outputs
	// ****************************************
	assign buffer_enable_bit_out     = enable_q;
	assign id_length_select_bits_out = id_fmt_q;

	// ****************************************
	// Read path
	// ****************************************
	// Cancel is write-only and, like any unmapped offset, reads as zero.
	always_comb
	begin
		rd_word = cbtx_pkg::UNMAPPED_READ;
		unique case (wb_adr_in)
			cbtx_pkg::OFS_ID_FORMAT:   rd_word = {{(32-N){1'b0}}, id_fmt_q};
			cbtx_pkg::OFS_TX_REQUEST:  rd_word = rmw_q ? {{(32-N){1'b0}}, {N{1'b1}}}
				: {{(32-N){1'b0}}, send_pending_q};
			cbtx_pkg::OFS_ENABLE:      rd_word = {{(32-N){1'b0}}, enable_q};
			cbtx_pkg::OFS_FRAME_TYPE:  rd_word = {{(32-N){1'b0}}, frame_type_q};
			cbtx_pkg::OFS_REMOTE_WAIT: rd_word = {{(32-N){1'b0}}, remote_wait_q};
			cbtx_pkg::OFS_RX_REMOTE:   rd_word = {{(32-N){1'b0}}, rx_remote_q};
			cbtx_pkg::OFS_CTRL:        rd_word = {31'h0000_0000, rmw_q};
			default:                   rd_word = cbtx_pkg::UNMAPPED_READ;
		endcase
	end

	// Read data is captured with the request and stands until the next read.
	always_ff @(posedge ref_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			wb_dat_out <= cbtx_pkg::UNMAPPED_READ;
		else if (acc && !wb_we_in)
			wb_dat_out <= rd_word;
	end
endmodule : cbtx_top
`default_nettype wire

// >>> sim/cbtx_chk.sv
// Port checker of the buffer transmit-request block.
`default_nettype none
module cbtx_chk #(
	parameter int N = 8
) (
	input wire logic                 ref_clk_in,
	input wire logic                 nrst_in,
	input wire logic                 wb_cyc_in,
	input wire logic                 wb_stb_in,
	input wire logic                 wb_ack_out,
	input wire logic                 tx_busy_in,
	input wire logic                 tx_start_out,
	input wire logic [$clog2(N)-1:0] tx_idx_out,
	input wire logic                 tx_ext_id_out,
	input wire logic [N-1:0]         id_length_select_bits_out
);
	logic [N-1:0] fmt_q;
	always_ff @(posedge ref_clk_in)
		fmt_q <= id_length_select_bits_out;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!nrst_in);
	a_ack_answers_req: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
		else $error("no ack");
	a_ack_one_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("long ack");
	a_ack_has_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
		else $error("stray ack");
	a_start_not_busy: assert property (tx_start_out |-> !$past(tx_busy_in))
		else $error("start while busy");
	a_busy_run_idle: assert property (tx_busy_in [*2] |=> !tx_start_out)
		else $error("start in busy run");
	a_start_one_pulse: assert property (tx_start_out |=> !tx_start_out)
		else $error("long start");
	a_start_id_length: assert property (tx_start_out |-> tx_ext_id_out == fmt_q[tx_idx_out])
		else $error("bad id length");
	a_format_on_write: assert property ($changed(id_length_select_bits_out) |-> $past(wb_ack_out))
		else $error("format moved alone");
	c_launch: cover property (tx_start_out);
	c_launch_pair: cover property (tx_start_out ##[1:30] tx_start_out);
	c_launch_long_id: cover property (tx_start_out && tx_ext_id_out);
endmodule : cbtx_chk
bind cbtx_top cbtx_chk #(.N(N)) chk_u (.ref_clk_in, .nrst_in, .wb_cyc_in, .wb_stb_in,
	.wb_ack_out, .tx_busy_in, .tx_start_out, .tx_idx_out, .tx_ext_id_out,
	.id_length_select_bits_out);
`default_nettype wire

// >>> sim/cbtx_can.sv
// CAN engine model: each launch keeps it busy for eight cycles.
`default_nettype none
module cbtx_can (
	input wire logic       ref_clk_in,
	input wire logic       nrst_in,
	input wire logic       start_in,
	input wire logic [2:0] idx_in,
	output logic           busy_out,
	output logic           done_out,
	output logic [2:0]     done_idx_out
);
	logic [2:0] cur_q = 3'h0;
	logic [3:0] cnt_q;
	assign busy_out = cnt_q != 4'h0;
	// Off the done strobe the index is shown inverted, so a stale index is never trusted.
	assign done_idx_out = done_out ? cur_q : ~cur_q;
	always_ff @(posedge ref_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			cnt_q <= 4'h0;
		else
			cnt_q <= start_in ? 4'h8 : cnt_q - 4'(busy_out);
	end
	always_ff @(posedge ref_clk_in)
	begin
		done_out <= cnt_q == 4'h1;
		cur_q <= start_in ? idx_in : cur_q;
	end
endmodule : cbtx_can
`default_nettype wire

// >>> sim/test_cbtx_top.sv
// Self-checking bench of the buffer transmit-request block.
`default_nettype none
module test_cbtx_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, we = 1'b0, rrx = 1'b0, ack, busy, done, go, rem, ext;
	logic [2:0] rix = 3'h0, didx, idx;
	logic [7:0] adr = 8'h00, fmt, ben;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0000_0000, rnd = 32'hf0f6_9e56, rdat;
	logic [31:0] rq[$];
	logic [4:0] tq[$];
	int error_cnt = 0, check_count = 0;
	always #5 clk = ~clk;
	cbtx_top dut_u (.ref_clk_in(clk), .nrst_in(nrst), .wb_cyc_in(cyc), .wb_stb_in(cyc),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .tx_busy_in(busy), .tx_done_in(done), .tx_done_idx_in(didx),
		.rx_remote_in(rrx), .rx_remote_idx_in(rix), .tx_start_out(go), .tx_idx_out(idx),
		.tx_remote_out(rem), .tx_ext_id_out(ext), .buffer_enable_bit_out(ben),
		.id_length_select_bits_out(fmt));
	cbtx_can can_u (.ref_clk_in(clk), .nrst_in(nrst), .start_in(go), .idx_in(idx),
		.busy_out(busy), .done_out(done), .done_idx_out(didx));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1)
		begin
			error_cnt++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		sel <= 4'hf;
		we <= w;
		adr <= a;
		dat <= d;
		do
			@(posedge clk);
		while (ack !== 1'b1);
		cyc <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rq.push_back({24'h00_0000, e});
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd
	task automatic stop_test;
		chk(rq.size() == 0 && tq.size() == 0, "result missing");
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	always @(posedge clk)
	begin
		if (ack === 1'b1 && we === 1'b0)
			chk(rq.size() > 0 && rdat === rq.pop_front(), "read data");
		if (go === 1'b1)
			chk(tq.size() > 0 && {rem, ext, idx} === tq.pop_front(), "launch");
	end
	initial
	begin
		#50000;
		error_cnt++;
		stop_test();
	end
	initial
	begin
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		for (int a = 0; a <= 32; a += 4)
			rd(8'(a), 8'h00);
		rnd = lfsr(rnd);
		bus(1'b1, 8'h00, rnd);
		rd(8'h00, rnd[7:0]);
		chk(fmt === rnd[7:0], "format out");
		bus(1'b1, 8'h1c, 32'h0000_0001);
		rd(8'h04, 8'hff);
		bus(1'b1, 8'h1c, 32'h0000_0000);
		$display("test registers end");
		bus(1'b1, 8'h08, 32'h0000_007f);
		chk(ben === 8'h7f, "enable out");
		tq.push_back({1'b0, rnd[2], 3'h2});
		tq.push_back({1'b0, rnd[5], 3'h5});
		bus(1'b1, 8'h04, 32'h0000_00a4);
		repeat (40) @(posedge clk);
		rd(8'h04, 8'h80);
		bus(1'b1, 8'h0c, 32'h0000_0080);
		rd(8'h04, 8'h00);
		$display("test launch end");
		bus(1'b1, 8'h14, 32'h0000_0022);
		bus(1'b1, 8'h04, 32'h0000_0002);
		repeat (20) @(posedge clk);
		rd(8'h04, 8'h02);
		tq.push_back({1'b0, rnd[1], 3'h1});
		tq.push_back({1'b0, rnd[3], 3'h3});
		tq.push_back({1'b1, rnd[5], 3'h5});
		rix <= 3'h1;
		rrx <= 1'b1;
		@(posedge clk);
		rix <= 3'h3;
		@(posedge clk);
		rrx <= 1'b0;
		rix <= 3'h4;
		bus(1'b1, 8'h10, 32'h0000_0020);
		bus(1'b1, 8'h04, 32'h0000_0028);
		repeat (60) @(posedge clk);
		rd(8'h04, 8'h00);
		$display("test remote end");
		tq.push_back({1'b0, rnd[0], 3'h0});
		bus(1'b1, 8'h04, 32'h0000_0001);
		@(posedge clk iff go === 1'b1);
		// The new request lands on the very edge at which the send completes.
		repeat (7) @(posedge clk);
		bus(1'b1, 8'h04, 32'h0000_0001);
		repeat (4) @(posedge clk);
		rd(8'h04, 8'h00);
		bus(1'b1, 8'h08, 32'h0000_0000);
		chk(ben === 8'h00, "enable out");
		$display("test collide end");
		stop_test();
	end
endmodule : test_cbtx_top
`default_nettype wire
